// ===== core/ovl_brake_pkg.sv
// constants for the overload stop and brake release block
package ovl_brake_pkg;
   // register byte offsets
   localparam logic [7:0] CFG_OFS        = 8'h00;
   localparam logic [7:0] OVL_LEVEL_OFS  = 8'h04;
   localparam logic [7:0] OVL_TIME_OFS   = 8'h08;
   localparam logic [7:0] REL_CUR_OFS    = 8'h0C;
   localparam logic [7:0] REL_FREQ_OFS   = 8'h10;
   localparam logic [7:0] REL_TIME_OFS   = 8'h14;
   localparam logic [7:0] REL_TRQ_OFS    = 8'h18;
   localparam logic [7:0] APP_FREQ_OFS   = 8'h1C;
   localparam logic [7:0] APP_TIME_OFS   = 8'h20;
   localparam logic [7:0] IN_FUNC_OFS    = 8'h24;
   localparam logic [7:0] OUT_FUNC_OFS   = 8'h28;
   localparam logic [7:0] STATUS_OFS     = 8'h2C;
   localparam logic [7:0] IRQ_STAT_OFS   = 8'h30;
   localparam logic [7:0] IRQ_MASK_OFS   = 8'h34;
   // configuration field positions
   localparam int CFG_ITEM_BIT   = 0;
   localparam int CFG_ACT_LSB    = 1;
   localparam int CFG_PHASE_LSB  = 3;
   localparam int CFG_PMSM_BIT   = 5;
   localparam int CFG_VEC_BIT    = 6;
   localparam int CFG_W          = 7;
   localparam logic [6:0] CFG_RESET = 7'h00;
   // selector encodings
   localparam logic       ITEM_TORQUE   = 1'b0;
   localparam logic       ITEM_CURRENT  = 1'b1;
   localparam logic [1:0] ACT_DISABLE   = 2'h0;
   localparam logic [1:0] ACT_DECEL     = 2'h1;
   localparam logic [1:0] ACT_COAST     = 2'h2;
   localparam logic [1:0] PH_CONST_DEC  = 2'h0;
   localparam logic [1:0] PH_CONST      = 2'h1;
   localparam logic [1:0] PH_ALWAYS     = 2'h2;
   localparam logic [7:0] FUNC_OVL_EN   = 8'h2E;
   localparam logic [7:0] FUNC_BRAKE    = 8'h39;
   // levels in hundredths of a percent, times in hundredths of a second
   localparam logic [15:0] LEVEL_MAX    = 16'h7530;
   localparam logic [15:0] TIME_MAX     = 16'h01F4;
   localparam logic [15:0] PMSM_SPEED   = 16'h03E8;
   // interrupt status and mask bit positions
   localparam int EV_TRIP    = 0;
   localparam int EV_RELEASE = 1;
   localparam int EV_APPLY   = 2;
   localparam int EV_W       = 3;
   // timer tick: one hundredth of a second
   localparam int CLK_MHZ     = 250;
   localparam int TICK_US     = 10000;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
endpackage : ovl_brake_pkg

// ===== core/sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sync2

// ===== core/persist_timer.sv
// tick-based persistence timer that restarts when its condition lapses
`timescale 1ns/1ps
module persist_timer (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        tick,
   input  wire logic        cond,
   input  wire logic [15:0] limit,
   output logic             done
);
   logic [15:0] cnt_q;

   assign done = cond && (cnt_q >= limit);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 16'h0000;
      end else if (!cond) begin
         cnt_q <= 16'h0000;
      end else if (tick && cnt_q < limit) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule : persist_timer

// ===== core/ovl_brake.sv
// overload stop monitor and brake release control with an AHB-Lite register slave
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps

module ovl_brake #(
   parameter int TICK_CYCLES = ovl_brake_pkg::TICK_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        run_cmd_pin,
   input  wire logic        overload_stop_enable,
   input  wire logic [15:0] torque_pct,
   input  wire logic [15:0] current_pct,
   input  wire logic [15:0] out_freq,
   input  wire logic [15:0] speed_pct,
   input  wire logic        phase_accel,
   input  wire logic        phase_const,
   input  wire logic        phase_decel,
   output logic             run_enable,
   output logic             stop_decel,
   output logic             stop_coast,
   output logic             brake_release_cmd,
   output logic             overload_event,
   output logic             irq
);
   typedef enum logic [2:0] {
      OVL_IDLE  = 3'b001,
      OVL_DECEL = 3'b010,
      OVL_COAST = 3'b100
   } ovl_state_e;

   typedef enum logic [1:0] {
      BRK_APPLIED  = 2'b01,
      BRK_RELEASED = 2'b10
   } brk_state_e;

   // synchronised pins
   logic [1:0] pin_s;
   logic       run_s;
   logic       en_pin_s;

   sync2 #(.W(2)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({run_cmd_pin, overload_stop_enable}),
      .q       (pin_s)
   );
   assign run_s = pin_s[1];
   assign en_pin_s = pin_s[0];

   // 10 ms tick divider
   logic [31:0] div_q;
   logic        tick_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q  <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == 32'(TICK_CYCLES - 1));
         div_q  <= (div_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_q + 32'h0000_0001;
      end
   end

   // registers
   logic [ovl_brake_pkg::CFG_W-1:0] cfg_q;
   logic [15:0]                     ovl_level_q;
   logic [15:0]                     ovl_time_q;
   logic [15:0]                     rel_cur_q;
   logic [15:0]                     rel_freq_q;
   logic [15:0]                     rel_time_q;
   logic [15:0]                     rel_trq_q;
   logic [15:0]                     app_freq_q;
   logic [15:0]                     app_time_q;
   logic [7:0]                      in_func_q;
   logic [7:0]                      out_func_q;
   logic [ovl_brake_pkg::EV_W-1:0]  irq_stat_q;
   logic [ovl_brake_pkg::EV_W-1:0]  irq_mask_q;

   wire       item_sel  = cfg_q[ovl_brake_pkg::CFG_ITEM_BIT];
   wire [1:0] act_sel   = cfg_q[ovl_brake_pkg::CFG_ACT_LSB +: 2];
   wire [1:0] phase_sel = cfg_q[ovl_brake_pkg::CFG_PHASE_LSB +: 2];
   wire       pmsm      = cfg_q[ovl_brake_pkg::CFG_PMSM_BIT];
   wire       vec_pg    = cfg_q[ovl_brake_pkg::CFG_VEC_BIT];

   // AHB-Lite address phase capture
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;

   wire        addr_ok  = hsel && hready && htrans[1];
   wire        rd_take  = addr_ok && !hwrite;
   wire        wr_take  = addr_ok && hwrite;
   wire [7:0]  a_ofs    = haddr[7:0];
   wire        wr_now   = wr_pend_q;
   wire [15:0] wd16     = hwdata[15:0];
   wire [15:0] wd_level = (wd16 > ovl_brake_pkg::LEVEL_MAX) ? ovl_brake_pkg::LEVEL_MAX : wd16;
   wire [15:0] wd_time  = (wd16 > ovl_brake_pkg::TIME_MAX) ? ovl_brake_pkg::TIME_MAX : wd16;
   wire        rd_irq   = rd_take && (a_ofs == ovl_brake_pkg::IRQ_STAT_OFS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= wr_take;
         wr_addr_q <= wr_take ? a_ofs : wr_addr_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q       <= ovl_brake_pkg::CFG_RESET;
         ovl_level_q <= 16'h0000;
         ovl_time_q  <= 16'h0000;
         rel_cur_q   <= 16'h0000;
         rel_freq_q  <= 16'h0000;
         rel_time_q  <= 16'h0000;
         rel_trq_q   <= 16'h0000;
         app_freq_q  <= 16'h0000;
         app_time_q  <= 16'h0000;
         in_func_q   <= 8'h00;
         out_func_q  <= 8'h00;
         irq_mask_q  <= '0;
      end else if (wr_now) begin
         case (wr_addr_q)
            ovl_brake_pkg::CFG_OFS:       cfg_q       <= hwdata[ovl_brake_pkg::CFG_W-1:0];
            ovl_brake_pkg::OVL_LEVEL_OFS: ovl_level_q <= wd16;
            ovl_brake_pkg::OVL_TIME_OFS:  ovl_time_q  <= wd16;
            ovl_brake_pkg::REL_CUR_OFS:   rel_cur_q   <= wd_level;
            ovl_brake_pkg::REL_FREQ_OFS:  rel_freq_q  <= wd16;
            ovl_brake_pkg::REL_TIME_OFS:  rel_time_q  <= wd_time;
            ovl_brake_pkg::REL_TRQ_OFS:   rel_trq_q   <= wd_level;
            ovl_brake_pkg::APP_FREQ_OFS:  app_freq_q  <= wd16;
            ovl_brake_pkg::APP_TIME_OFS:  app_time_q  <= wd_time;
            ovl_brake_pkg::IN_FUNC_OFS:   in_func_q   <= hwdata[7:0];
            ovl_brake_pkg::OUT_FUNC_OFS:  out_func_q  <= hwdata[7:0];
            ovl_brake_pkg::IRQ_MASK_OFS:  irq_mask_q  <= hwdata[ovl_brake_pkg::EV_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // overload detection
   ovl_state_e ovl_q;
   ovl_state_e ovl_d;
   logic       trip_flag_q;
   logic       run_int_q;

   wire [15:0] load_val = (item_sel == ovl_brake_pkg::ITEM_CURRENT) ? current_pct : torque_pct;
   wire        over     = load_val > ovl_level_q;
   wire        ph_ok    = (phase_sel == ovl_brake_pkg::PH_ALWAYS) ||
                          (phase_sel == ovl_brake_pkg::PH_CONST && phase_const) ||
                          (phase_sel == ovl_brake_pkg::PH_CONST_DEC && (phase_const || phase_decel));
   wire        term_use = (in_func_q == ovl_brake_pkg::FUNC_OVL_EN);
   wire        ovl_en   = term_use ? en_pin_s : 1'b1;
   wire        pmsm_blk = pmsm && (speed_pct <= ovl_brake_pkg::PMSM_SPEED);
   wire        act_on   = (act_sel == ovl_brake_pkg::ACT_DECEL) || (act_sel == ovl_brake_pkg::ACT_COAST);
   wire        ovl_qual = run_int_q && over && ph_ok && ovl_en && !pmsm_blk && act_on;
   wire        ovl_done;
   wire        trip     = (ovl_q == OVL_IDLE) && ovl_done;

   persist_timer u_ovl_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick_q),
      .cond    (ovl_qual),
      .limit   (ovl_time_q),
      .done    (ovl_done)
   );

   always_comb begin
      ovl_d = ovl_q;
      case (ovl_q)
         OVL_IDLE: begin
            if (trip) begin
               ovl_d = (act_sel == ovl_brake_pkg::ACT_COAST) ? OVL_COAST : OVL_DECEL;
            end
         end
         OVL_DECEL, OVL_COAST: begin
            if (!run_s) begin
               ovl_d = OVL_IDLE;
            end
         end
         default: ovl_d = OVL_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovl_q       <= OVL_IDLE;
         trip_flag_q <= 1'b0;
         run_int_q   <= 1'b0;
      end else begin
         ovl_q       <= ovl_d;
         trip_flag_q <= trip || (trip_flag_q && run_s);
         run_int_q   <= run_s && (ovl_d == OVL_IDLE);
      end
   end

   // brake control
   brk_state_e brk_q;
   brk_state_e brk_d;
   logic       rearm_q;
   wire        rel_done;
   wire        app_done;
   wire        trq_ok   = !vec_pg || (torque_pct > rel_trq_q);
   wire        rel_qual = run_int_q && rearm_q && (current_pct > rel_cur_q) &&
                          (out_freq > rel_freq_q) && trq_ok;
   wire        app_qual = !run_s && (out_freq < app_freq_q);
   wire        coasting = (ovl_q == OVL_COAST);

   persist_timer u_rel_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick_q),
      .cond    (rel_qual && brk_q == BRK_APPLIED),
      .limit   (rel_time_q),
      .done    (rel_done)
   );

   persist_timer u_app_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick_q),
      .cond    (app_qual && brk_q == BRK_RELEASED),
      .limit   (app_time_q),
      .done    (app_done)
   );

   wire rel_ev = (brk_q == BRK_APPLIED) && (brk_d == BRK_RELEASED);
   wire app_ev = (brk_q == BRK_RELEASED) && (brk_d == BRK_APPLIED);

   always_comb begin
      brk_d = brk_q;
      case (brk_q)
         BRK_APPLIED: begin
            if (rel_done && !coasting) begin
               brk_d = BRK_RELEASED;
            end
         end
         BRK_RELEASED: begin
            // coast stop drops the brake at once
            if (app_done || coasting) begin
               brk_d = BRK_APPLIED;
            end
         end
         default: brk_d = BRK_APPLIED;
      endcase
   end

   // a new release needs the run command to drop after an apply
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         brk_q   <= BRK_APPLIED;
         rearm_q <= 1'b1;
      end else begin
         brk_q   <= brk_d;
         rearm_q <= !run_s || (rearm_q && !app_ev);
      end
   end

   // interrupt status: set by events, cleared by a read, set wins
   wire [ovl_brake_pkg::EV_W-1:0] ev_vec;
   assign ev_vec[ovl_brake_pkg::EV_TRIP]    = trip;
   assign ev_vec[ovl_brake_pkg::EV_RELEASE] = rel_ev;
   assign ev_vec[ovl_brake_pkg::EV_APPLY]   = app_ev;

   genvar gi;
   generate
      for (gi = 0; gi < ovl_brake_pkg::EV_W; gi++) begin : g_irq
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               irq_stat_q[gi] <= 1'b0;
            end else begin
               irq_stat_q[gi] <= ev_vec[gi] || (irq_stat_q[gi] && !rd_irq);
            end
         end
      end
   endgenerate

   // read mux
   wire [31:0] status_w = {27'h0000000, ovl_q == OVL_COAST, ovl_q == OVL_DECEL,
                           run_int_q, brk_q == BRK_RELEASED, trip_flag_q};
   logic [31:0] rd_mux;

   always_comb begin
      case (a_ofs)
         ovl_brake_pkg::CFG_OFS:       rd_mux = {25'h0000000, cfg_q};
         ovl_brake_pkg::OVL_LEVEL_OFS: rd_mux = {16'h0000, ovl_level_q};
         ovl_brake_pkg::OVL_TIME_OFS:  rd_mux = {16'h0000, ovl_time_q};
         ovl_brake_pkg::REL_CUR_OFS:   rd_mux = {16'h0000, rel_cur_q};
         ovl_brake_pkg::REL_FREQ_OFS:  rd_mux = {16'h0000, rel_freq_q};
         ovl_brake_pkg::REL_TIME_OFS:  rd_mux = {16'h0000, rel_time_q};
         ovl_brake_pkg::REL_TRQ_OFS:   rd_mux = {16'h0000, rel_trq_q};
         ovl_brake_pkg::APP_FREQ_OFS:  rd_mux = {16'h0000, app_freq_q};
         ovl_brake_pkg::APP_TIME_OFS:  rd_mux = {16'h0000, app_time_q};
         ovl_brake_pkg::IN_FUNC_OFS:   rd_mux = {24'h000000, in_func_q};
         ovl_brake_pkg::OUT_FUNC_OFS:  rd_mux = {24'h000000, out_func_q};
         ovl_brake_pkg::STATUS_OFS:    rd_mux = status_w;
         ovl_brake_pkg::IRQ_STAT_OFS:  rd_mux = {29'h0000000, irq_stat_q};
         ovl_brake_pkg::IRQ_MASK_OFS:  rd_mux = {29'h0000000, irq_mask_q};
         default:                      rd_mux = 32'h0000_0000;
      endcase
   end

   // outputs, all registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout         <= 1'b1;
         hresp             <= 1'b0;
         hrdata            <= 32'h0000_0000;
         run_enable        <= 1'b0;
         stop_decel        <= 1'b0;
         stop_coast        <= 1'b0;
         brake_release_cmd <= 1'b0;
         overload_event    <= 1'b0;
         irq               <= 1'b0;
      end else begin
         hreadyout         <= 1'b1;
         hresp             <= 1'b0;
         hrdata            <= rd_take ? rd_mux : hrdata;
         run_enable        <= run_int_q;
         stop_decel        <= (ovl_q == OVL_DECEL);
         stop_coast        <= (ovl_q == OVL_COAST);
         brake_release_cmd <= (out_func_q == ovl_brake_pkg::FUNC_BRAKE) && (brk_q == BRK_RELEASED);
         overload_event    <= trip_flag_q;
         irq               <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule : ovl_brake

// ===== verification/ovl_brake_props.sv
// port assertions for the overload stop and brake release block
`timescale 1ns/1ps
module ovl_brake_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic run_cmd_pin,
   input wire logic run_enable,
   input wire logic stop_decel,
   input wire logic stop_coast,
   input wire logic brake_release_cmd,
   input wire logic overload_event
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   AST_ONE_ACTION: assert property (!(stop_decel && stop_coast))
      else $error("decel and coast stop both active");
   AST_STOP_BLOCKS_RUN: assert property ((stop_decel || stop_coast) |-> !run_enable)
      else $error("run enabled during overload stop");
   AST_STOP_HOLDS: assert property ((stop_decel || stop_coast) && run_cmd_pin |=> $stable({stop_decel, stop_coast}))
      else $error("overload stop left while run held");
   AST_RESTART_NEEDS_RUN: assert property ($rose(run_enable) |-> $past(run_cmd_pin, 3) && !overload_event)
      else $error("run enabled without fresh run command");
   AST_EVENT_WITH_STOP: assert property ($rose(overload_event) |-> (stop_decel || stop_coast) && !run_enable)
      else $error("overload flag without stop");
   AST_EVENT_HELD: assert property (overload_event && run_cmd_pin |=> overload_event)
      else $error("overload flag dropped while run held");
   AST_BRAKE_RELEASE_RUN: assert property ($rose(brake_release_cmd) |-> run_enable && $past(run_enable))
      else $error("brake released without running");
   AST_BRAKE_APPLY: assert property ($fell(brake_release_cmd) |-> !run_enable)
      else $error("brake applied while running");
   AST_COAST_BRAKE: assert property ($rose(stop_coast) |-> ##[0:3] !brake_release_cmd)
      else $error("brake not applied on coast stop");

   cover property ($rose(stop_decel));
   cover property ($rose(stop_coast));
   cover property ($rose(brake_release_cmd));
endmodule : ovl_brake_props

// ===== verification/drive_model.sv
// behavioural drive around the block: ramped frequency, load and run phase
`timescale 1ns/1ps
module drive_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        run_enable,
   input  wire logic        stop_coast,
   input  wire logic [15:0] load_pct,
   input  wire logic [15:0] freq_set,
   output logic      [15:0] torque_pct,
   output logic      [15:0] current_pct,
   output logic      [15:0] out_freq,
   output logic      [15:0] speed_pct,
   output logic             phase_accel,
   output logic             phase_const,
   output logic             phase_decel
);
   logic [15:0] target;

   assign target      = run_enable ? freq_set : 16'h0000;
   assign torque_pct  = load_pct;
   // no-load current rides on top of the torque share
   assign current_pct = load_pct + 16'h03E8;
   assign speed_pct   = out_freq * 16'h000A;
   assign phase_accel = out_freq < target;
   assign phase_decel = out_freq > target;
   assign phase_const = (out_freq == target) && (target != 16'h0000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_freq <= 16'h0000;
      end else if (stop_coast) begin
         out_freq <= 16'h0000;
      end else if (out_freq + 16'h000A <= target) begin
         out_freq <= out_freq + 16'h000A;
      end else if (out_freq >= target + 16'h000A) begin
         out_freq <= out_freq - 16'h000A;
      end else begin
         out_freq <= target;
      end
   end
endmodule : drive_model

// ===== verification/ovl_brake_bench.sv
// self-checking bench for the overload stop and brake release block
`timescale 1ns/1ps
module ovl_brake_bench;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic        run_cmd_pin, ovl_en_pin, phase_accel, phase_const, phase_decel;
   logic        run_enable, stop_decel, stop_coast, brake_release_cmd, overload_event, irq;
   logic [15:0] load_pct, freq_set, torque_pct, current_pct, out_freq, speed_pct;
   int          err_count = 0;
   int          checked = 0;

   assign hready = hreadyout;

   ovl_brake #(.TICK_CYCLES(10)) uut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .run_cmd_pin, .overload_stop_enable(ovl_en_pin),
      .torque_pct, .current_pct, .out_freq, .speed_pct, .phase_accel, .phase_const, .phase_decel,
      .run_enable, .stop_decel, .stop_coast, .brake_release_cmd, .overload_event, .irq);

   drive_model drive (.hclk, .hresetn, .run_enable, .stop_coast, .load_pct, .freq_set, .torque_pct,
      .current_pct, .out_freq, .speed_pct, .phase_accel, .phase_const, .phase_decel);

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         $display("unexpected %s: expected %h seen %h", name, want, seen);
         err_count++;
      end
   endtask : check

   // one single transfer; entered and left just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h00000000, q);
      check($sformatf("register %h", a), q, want);
   endtask : rdchk

   function automatic logic sigv(input int i);
      case (i)
         0: sigv = brake_release_cmd;
         1: sigv = stop_decel;
         2: sigv = stop_coast;
         3: sigv = overload_event;
         4: sigv = irq;
         default: sigv = run_enable;
      endcase
   endfunction : sigv

   task automatic wait_sig(input int i, input logic v, input int lim);
      int n;
      n = 0;
      while (sigv(i) !== v && n < lim) begin
         @(posedge hclk);
         n++;
      end
      check($sformatf("output %0d", i), sigv(i), v);
   endtask : wait_sig

   task automatic hold(input int i, input logic v, input int n);
      repeat (n) begin
         @(posedge hclk);
         check($sformatf("output %0d", i), sigv(i), v);
      end
   endtask : hold

   // fresh start with a new setting: run off, settle, run on
   task automatic trial(input logic [31:0] cfg, input logic [15:0] fs, input int quiet, input logic trips);
      run_cmd_pin <= 1'b0;
      wait_sig(3, 1'b0, 20);
      repeat (120) @(posedge hclk);
      wr(ovl_brake_pkg::CFG_OFS, cfg);
      freq_set    <= fs;
      run_cmd_pin <= 1'b1;
      hold(3, 1'b0, quiet);
      if (trips) begin
         wait_sig(3, 1'b1, 80);
      end
   endtask : trial

   initial begin
      // generous bound, the sequence needs a few thousand cycles
      #(4 * 20000);
      err_count++;
      end_sim();
   end

   initial begin
      hresetn     <= 1'b0;
      hsel        <= 1'b0;
      haddr       <= 32'h00000000;
      htrans      <= 2'h0;
      hwrite      <= 1'b0;
      hwdata      <= 32'h00000000;
      run_cmd_pin <= 1'b0;
      ovl_en_pin  <= 1'b0;
      load_pct    <= 16'h0000;
      freq_set    <= 16'h0000;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(ovl_brake_pkg::CFG_OFS, 32'h00000000);
      rdchk(ovl_brake_pkg::STATUS_OFS, 32'h00000000);
      wr(8'h40, 32'h0000FFFF);
      rdchk(8'h40, 32'h00000000);
      wr(ovl_brake_pkg::REL_CUR_OFS, 32'h0000FFFF);
      rdchk(ovl_brake_pkg::REL_CUR_OFS, {16'h0000, ovl_brake_pkg::LEVEL_MAX});
      wr(ovl_brake_pkg::REL_TIME_OFS, 32'h00000258);
      rdchk(ovl_brake_pkg::REL_TIME_OFS, {16'h0000, ovl_brake_pkg::TIME_MAX});
      wr(ovl_brake_pkg::REL_CUR_OFS, 32'h000007D0);
      wr(ovl_brake_pkg::REL_TIME_OFS, 32'h00000002);
      wr(ovl_brake_pkg::REL_FREQ_OFS, 32'h000001F4);
      wr(ovl_brake_pkg::REL_TRQ_OFS, 32'h00007530);
      wr(ovl_brake_pkg::APP_FREQ_OFS, 32'h00000064);
      wr(ovl_brake_pkg::APP_TIME_OFS, 32'h00000001);
      wr(ovl_brake_pkg::OVL_TIME_OFS, 32'h00000003);
      wr(ovl_brake_pkg::OVL_LEVEL_OFS, 32'h00001388);
      wr(ovl_brake_pkg::OUT_FUNC_OFS, {24'h000000, ovl_brake_pkg::FUNC_BRAKE});
      wr(ovl_brake_pkg::IRQ_MASK_OFS, 32'h00000003);
      wr(ovl_brake_pkg::CFG_OFS, 32'h00000052);
      load_pct    <= 16'h0BB8;
      freq_set    <= 16'h03E8;
      run_cmd_pin <= 1'b1;
      wait_sig(5, 1'b1, 20);
      hold(0, 1'b0, 150);
      wr(ovl_brake_pkg::CFG_OFS, 32'h00000012);
      hold(0, 1'b0, 10);
      wait_sig(0, 1'b1, 60);
      wait_sig(4, 1'b1, 4);
      rdchk(ovl_brake_pkg::IRQ_STAT_OFS, 32'h00000002);
      rdchk(ovl_brake_pkg::STATUS_OFS, 32'h00000006);
      check("irq", irq, 1'b0);
      // torque 45.00, current 55.00 against a 50.00 level
      load_pct <= 16'h1194;
      hold(3, 1'b0, 80);
      wr(ovl_brake_pkg::CFG_OFS, 32'h00000013);
      hold(3, 1'b0, 12);
      wr(ovl_brake_pkg::CFG_OFS, 32'h00000012);
      hold(3, 1'b0, 80);
      wr(ovl_brake_pkg::CFG_OFS, 32'h00000013);
      hold(3, 1'b0, 20);
      wait_sig(3, 1'b1, 40);
      check("decel stop", stop_decel, 1'b1);
      check("coast stop", stop_coast, 1'b0);
      wait_sig(4, 1'b1, 3);
      rdchk(ovl_brake_pkg::IRQ_STAT_OFS, 32'h00000001);
      hold(5, 1'b0, 30);
      load_pct    <= 16'h0000;
      run_cmd_pin <= 1'b0;
      wait_sig(3, 1'b0, 8);
      wait_sig(0, 1'b0, 150);
      hold(4, 1'b0, 3);
      rdchk(ovl_brake_pkg::IRQ_STAT_OFS, 32'h00000004);
      wr(ovl_brake_pkg::OUT_FUNC_OFS, 32'h00000000);
      run_cmd_pin <= 1'b1;
      wait_sig(5, 1'b1, 8);
      wr(ovl_brake_pkg::IN_FUNC_OFS, {24'h000000, ovl_brake_pkg::FUNC_OVL_EN});
      wr(ovl_brake_pkg::CFG_OFS, 32'h00000015);
      load_pct <= 16'h1194;
      // brake released inside, but no terminal carries it
      repeat (120) @(posedge hclk);
      rdchk(ovl_brake_pkg::STATUS_OFS, 32'h00000006);
      check("brake output", brake_release_cmd, 1'b0);
      wr(ovl_brake_pkg::OUT_FUNC_OFS, {24'h000000, ovl_brake_pkg::FUNC_BRAKE});
      wait_sig(0, 1'b1, 200);
      hold(3, 1'b0, 60);
      ovl_en_pin <= 1'b1;
      wait_sig(2, 1'b1, 60);
      wait_sig(0, 1'b0, 4);
      trial(32'h00000011, 16'h03E8, 150, 1'b0);
      trial(32'h00000035, 16'h0032, 120, 1'b0);
      freq_set <= 16'h00C8;
      wait_sig(3, 1'b1, 80);
      trial(32'h0000000B, 16'h03E8, 90, 1'b1);
      trial(32'h00000003, 16'h03E8, 90, 1'b1);
      end_sim();
   end
endmodule : ovl_brake_bench

bind ovl_brake ovl_brake_props props (.hclk, .hresetn, .hreadyout, .hresp, .run_cmd_pin, .run_enable,
   .stop_decel, .stop_coast, .brake_release_cmd, .overload_event);
